// ### rtl/averager_map.svh
// Constants for the current and power averager: register offsets, field
// positions, reset values and converter timing counts.
// Assumes a 25 MHz system clock and a shared converter outside the block.
// Contract
// RULE1: One 16-bit converter serves shunt and bus channels, never both at once.
// RULE2: Bus channel measures negative input to ground; shunt channel is differential.
// RULE3: Current and power are computed only after a shunt then bus sample.
// RULE4: Power is the previous current times the latest bus voltage.
// RULE5: Power reads zero whenever the calibration value is zero.
// RULE6: With averaging above one, results go to an internal accumulator first.
// RULE7: Each sample's current and power add into the accumulator until count reached.
// RULE8: When all samples are done, averages load into the readable output registers.
// RULE9: Arithmetic runs beside conversions and never lengthens conversion time (here the sequencer waits in ST_CALC for the result before the next start).
// RULE10: Mode 111 converts shunt then bus continuously.
// RULE11: Mode 001 starts one measurement set per configuration write.
// RULE12: Done flag sets only after conversions, averaging and multiply finish.
// RULE13: Output registers hold previous averages until a new cycle replaces them.
`ifndef AVERAGER_MAP_SVH
`define AVERAGER_MAP_SVH

`define REG_CONFIG_OFS      4'h0
`define REG_CALIB_OFS       4'h1
`define REG_CURRENT_OFS     4'h2
`define REG_POWER_OFS       4'h3
`define REG_SHUNT_OFS       4'h4
`define REG_BUS_OFS         4'h5
`define REG_STATUS_OFS      4'h6
`define REG_MASK_OFS        4'h7

`define CFG_MODE_LSB        0
`define CFG_AVG_LSB         4
`define CFG_CT_LSB          8
`define CFG_RESET_VAL       16'h0017
`define CALIB_RESET_VAL     16'h0000
`define MASK_RESET_VAL      16'h0000

`define MODE_SINGLE         3'h1
`define MODE_CONT           3'h7

`define STAT_DONE_BIT       0
`define STAT_OVF_BIT        1

`define CLK_MHZ             25
`define CONV_TIME_US        140
`define CONV_CYCLES         (`CONV_TIME_US * `CLK_MHZ)

`endif

// ### rtl/averager_pkg.sv
// Types shared by the averager modules.
// Assumes averager_map.svh provides the numeric constants.
package averager_pkg;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_SHUNT = 5'b00010,
        ST_BUS   = 5'b00100,
        ST_CALC  = 5'b01000,
        ST_LOAD  = 5'b10000
    } seq_state_type;

    typedef enum logic [0:0] {
        CH_SHUNT = 1'b0,
        CH_BUS   = 1'b1
    } channel_type;

endpackage : averager_pkg

// ### rtl/sample_math.sv
// Current and power arithmetic for one shunt and bus sample pair.
// Assumes operands stay stable from start_in through the next cycle; two-cycle pipeline, power one cycle after current.
`timescale 1ns/10ps
module sample_math
    import averager_pkg::*;
(
    input  wire logic               clk_sys_in,
    input  wire logic               arst_n_in,
    input  wire logic               start_in,
    input  wire logic signed [15:0] shunt_in,
    input  wire logic        [15:0] bus_in,
    input  wire logic        [15:0] calib_in,
    output logic                    valid_out,
    output logic signed [15:0]      current_out,
    output logic        [15:0]      power_out
);
    typedef struct packed {
        logic               stage;
        logic               valid;
        logic signed [15:0] current;
        logic        [15:0] power;
    } math_state_type;

    math_state_type s_q;
    math_state_type s_d;

    logic signed [32:0] cur_prod;
    logic        [31:0] pwr_prod;
    logic        [15:0] cur_mag;

    always_comb
    begin
        s_d       = s_q;
        s_d.valid = 1'b0;
        s_d.stage = start_in;
        cur_prod  = shunt_in * $signed({1'b0, calib_in});
        cur_mag   = s_q.current[15] ? 16'(-s_q.current) : s_q.current;
        pwr_prod  = cur_mag * bus_in;
        if (start_in)
        begin
            s_d.current = 16'(cur_prod >>> 11);
        end
        // Power uses the current formed one cycle before. [RULE4]
        if (s_q.stage)
        begin
            s_d.power = (calib_in == 16'h0000) ? 16'h0000 // [RULE5]
                                               : pwr_prod[28:13];
            s_d.valid = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign valid_out   = s_q.valid;
    assign current_out = s_q.current;
    assign power_out   = s_q.power;

endmodule : sample_math

// ### rtl/current_power_averager.sv
// Sequencer and averager for a shunt/bus current and power monitor.
// Assumes an external converter answering conv_start_out with a result and
// a one-cycle conv_done_in on the same clock, and a plain register port.
`timescale 1ns/10ps
`include "averager_map.svh"
module current_power_averager
    import averager_pkg::*;
#(
    parameter int CONV_CYCLES_P = `CONV_CYCLES
)
(
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [15:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [15:0] rdata_out,
    output logic             conv_start_out,
    output logic             conv_channel_out,
    output logic             conv_differential_out,
    input  wire logic [15:0] conv_result_in,
    input  wire logic        conv_done_in,
    output logic             irq_out
);
    typedef struct packed {
        seq_state_type      state;
        logic        [15:0] config_r;
        logic        [15:0] calib;
        logic        [15:0] mask;
        logic        [1:0]  status;
        logic signed [15:0] current_out_r;
        logic        [15:0] power_out_r;
        logic        [15:0] shunt_r;
        logic        [15:0] bus_r;
        logic signed [25:0] cur_acc;
        logic        [25:0] pwr_acc;
        logic        [10:0] samples;
        logic               calc_pend;
        logic               conv_go;
        logic               channel;
        logic               trigger;
        logic        [15:0] rdata;
        logic        [31:0] watchdog;
    } avg_state_type;

    avg_state_type s_q;
    avg_state_type s_d;

    logic               math_valid;
    logic signed [15:0] math_current;
    logic        [15:0] math_power;
    logic        [2:0]  mode;
    logic        [10:0] avg_target;
    logic               set_done;
    logic               set_ovf;

    // Averaging code to sample count, also the shift used to divide.
    function automatic logic [10:0] avg_count(input logic [2:0] code);
        logic [10:0] n;
        case (code)
            3'h0:    n = 11'h001;
            3'h1:    n = 11'h004;
            3'h2:    n = 11'h010;
            3'h3:    n = 11'h040;
            3'h4:    n = 11'h080;
            3'h5:    n = 11'h100;
            3'h6:    n = 11'h200;
            3'h7:    n = 11'h400;
            default: n = 11'h001;
        endcase
        return n;
    endfunction : avg_count

    function automatic logic [3:0] avg_shift(input logic [2:0] code);
        logic [3:0] sh;
        case (code)
            3'h0:    sh = 4'h0;
            3'h1:    sh = 4'h2;
            3'h2:    sh = 4'h4;
            3'h3:    sh = 4'h6;
            3'h4:    sh = 4'h7;
            3'h5:    sh = 4'h8;
            3'h6:    sh = 4'h9;
            3'h7:    sh = 4'ha;
            default: sh = 4'h0;
        endcase
        return sh;
    endfunction : avg_shift

    assign mode       = s_q.config_r[`CFG_MODE_LSB +: 3];
    assign avg_target = avg_count(s_q.config_r[`CFG_AVG_LSB +: 3]);

    // The arithmetic sits in its own module; the sequencer waits in ST_CALC for
    // the multiplied pair before the next conversion starts. [RULE9]
    sample_math u_math (
        .clk_sys_in  (clk_sys_in),
        .arst_n_in   (arst_n_in),
        .start_in    (s_q.calc_pend),
        .shunt_in    (s_q.shunt_r),
        .bus_in      (s_q.bus_r),
        .calib_in    (s_q.calib),
        .valid_out   (math_valid),
        .current_out (math_current),
        .power_out   (math_power)
    );

    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = 16'h0000;
        s_d.conv_go   = 1'b0;
        s_d.calc_pend = 1'b0;
        set_done  = 1'b0;
        set_ovf   = 1'b0;

        // Register writes.
        if (wr_in)
        begin
            case (addr_in)
                `REG_CONFIG_OFS:
                begin
                    s_d.config_r = wdata_in;
                    s_d.trigger  = 1'b1; // [RULE11]
                    s_d.status[`STAT_DONE_BIT] = 1'b0;
                end
                `REG_CALIB_OFS: s_d.calib = wdata_in;
                `REG_MASK_OFS:  s_d.mask  = wdata_in;
                default: ;
            endcase
        end

        // One converter only: a new start is issued only from idle or
        // after the previous channel has returned its result. [RULE1]
        case (s_q.state)
            ST_IDLE:
            begin
                if ((mode == `MODE_CONT) || (s_q.trigger && mode == `MODE_SINGLE)) // [RULE10] [RULE11]
                begin
                    // A configuration write in this very cycle re-arms, so
                    // a fresh single-shot request is never swallowed.
                    s_d.trigger = wr_in && (addr_in == `REG_CONFIG_OFS);
                    s_d.channel = CH_SHUNT;
                    s_d.conv_go = 1'b1;
                    s_d.state   = ST_SHUNT;
                    s_d.watchdog = 32'h0;
                end
                else if (s_q.trigger)
                begin
                    s_d.trigger = wr_in && (addr_in == `REG_CONFIG_OFS);
                end
            end
            ST_SHUNT:
            begin
                if (conv_done_in)
                begin
                    s_d.shunt_r = conv_result_in;
                    s_d.channel = CH_BUS;
                    s_d.conv_go = 1'b1;
                    s_d.state   = ST_BUS;
                end
            end
            ST_BUS:
            begin
                if (conv_done_in)
                begin
                    s_d.bus_r     = conv_result_in;
                    s_d.calc_pend = 1'b1; // [RULE3]
                    s_d.state     = ST_CALC;
                end
            end
            ST_CALC:
            begin
                if (math_valid)
                begin
                    // Every result is an intermediate until the count ends. [RULE6] [RULE7]
                    s_d.cur_acc = s_q.cur_acc + 26'(math_current);
                    s_d.pwr_acc = s_q.pwr_acc + 26'(math_power);
                    s_d.samples = s_q.samples + 11'h001;
                    if (s_q.samples + 11'h001 >= avg_target)
                    begin
                        s_d.state = ST_LOAD;
                    end
                    else
                    begin
                        s_d.channel = CH_SHUNT;
                        s_d.conv_go = 1'b1;
                        s_d.state   = ST_SHUNT;
                    end
                end
            end
            ST_LOAD:
            begin
                // Outputs change only here, so reads see the last average. [RULE8] [RULE13]
                s_d.current_out_r = 16'(s_q.cur_acc >>>
                                        avg_shift(s_q.config_r[`CFG_AVG_LSB +: 3]));
                s_d.power_out_r   = 16'(s_q.pwr_acc >>
                                        avg_shift(s_q.config_r[`CFG_AVG_LSB +: 3]));
                s_d.cur_acc = '0;
                s_d.pwr_acc = '0;
                s_d.samples = '0;
                set_done    = 1'b1; // [RULE12]
                s_d.state   = ST_IDLE;
            end
            default:
            begin
                s_d.state = ST_IDLE;
            end
        endcase

        // A converter that never answers is reported and the set abandoned,
        // rather than hanging the sequencer forever.
        if (s_q.state == ST_SHUNT || s_q.state == ST_BUS)
        begin
            s_d.watchdog = s_q.watchdog + 32'h1;
            if (s_q.watchdog >= 32'(CONV_CYCLES_P) * 32'h8)
            begin
                set_ovf     = 1'b1;
                s_d.state   = ST_IDLE;
                s_d.samples = '0;
                s_d.cur_acc = '0;
                s_d.pwr_acc = '0;
            end
        end
        else
        begin
            s_d.watchdog = 32'h0;
        end

        // Register reads; a status read clears sticky bits, but a bit set
        // in the same cycle survives the clear.
        if (rd_in)
        begin
            case (addr_in)
                `REG_CONFIG_OFS:  s_d.rdata = s_q.config_r;
                `REG_CALIB_OFS:   s_d.rdata = s_q.calib;
                `REG_CURRENT_OFS: s_d.rdata = s_q.current_out_r;
                `REG_POWER_OFS:   s_d.rdata = s_q.power_out_r;
                `REG_SHUNT_OFS:   s_d.rdata = s_q.shunt_r;
                `REG_BUS_OFS:     s_d.rdata = s_q.bus_r;
                `REG_STATUS_OFS:
                begin
                    s_d.rdata  = {14'h0000, s_q.status};
                    s_d.status = 2'b00;
                end
                `REG_MASK_OFS:    s_d.rdata = s_q.mask;
                default:          s_d.rdata = 16'h0000;
            endcase
        end
        if (set_done)
        begin
            s_d.status[`STAT_DONE_BIT] = 1'b1;
        end
        if (set_ovf)
        begin
            s_d.status[`STAT_OVF_BIT] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            s_q          <= '0;
            s_q.state    <= ST_IDLE;
            s_q.config_r <= `CFG_RESET_VAL;
            s_q.calib    <= `CALIB_RESET_VAL;
            s_q.mask     <= `MASK_RESET_VAL;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign rdata_out        = s_q.rdata;
    assign conv_start_out   = s_q.conv_go;
    assign conv_channel_out = s_q.channel;
    // Shunt is IN+ minus IN-; bus is IN- against ground. [RULE2]
    assign conv_differential_out = (s_q.channel == CH_SHUNT);
    assign irq_out = |(s_q.status & s_q.mask[1:0]);

endmodule : current_power_averager

// ### dv/averager_monitor.sv
// Checker on the averager's converter and register ports.
// Assumes a bind onto current_power_averager with a single clock.
`timescale 1ns/10ps
module averager_monitor
(
    input wire logic        clk_sys_in,
    input wire logic        arst_n_in,
    input wire logic [3:0]  addr_in,
    input wire logic        rd_in,
    input wire logic        wr_in,
    input wire logic [15:0] rdata_out,
    input wire logic        conv_start_out,
    input wire logic        conv_channel_out,
    input wire logic        conv_differential_out,
    input wire logic        conv_done_in,
    input wire logic        irq_out
);
    logic       busy_q;
    logic [7:0] gap_q;
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!arst_n_in);
    // Cycles since the last bus result bound how late the done flag may be.
    always_ff @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy_q <= 1'b0;
            gap_q  <= 8'hff;
        end
        else
        begin
            busy_q <= conv_start_out | (busy_q & ~conv_done_in);
            if (conv_done_in && busy_q && conv_channel_out)
                gap_q <= 8'h00;
            else if (gap_q != 8'hff)
                gap_q <= gap_q + 8'h01;
        end
    end
    sequence shunt_done_s;
        conv_done_in && busy_q && !conv_channel_out;
    endsequence
    sequence bus_start_s;
        conv_start_out && conv_channel_out;
    endsequence
    one_pulse_a: assert property (
        conv_start_out |=> !conv_start_out)
        else $error("start pulse too long");
    no_overlap_a: assert property (
        conv_start_out |-> !busy_q)
        else $error("start while converting");
    chan_hold_a: assert property (
        busy_q && !conv_start_out |-> $stable(conv_channel_out))
        else $error("channel moved mid conversion");
    input_select_a: assert property (
        conv_start_out |-> conv_differential_out == !conv_channel_out)
        else $error("wrong input pairing");
    shunt_bus_a: assert property (
        shunt_done_s |=> bus_start_s)
        else $error("bus sample not next after shunt");
    done_late_a: assert property (
        $rose(irq_out) && !$past(wr_in) |-> gap_q <= 8'd10)
        else $error("done without a recent bus result");
    irq_clear_a: assert property (
        rd_in && addr_in == 4'h6 |=> !irq_out)
        else $error("status read left irq high");
    rdata_idle_a: assert property (
        !$past(rd_in) |-> rdata_out == 16'h0000)
        else $error("read data outside answer cycle");
endmodule : averager_monitor

// ### dv/converter_model.sv
// Behavioural shared converter facing the averager.
// Assumes start pulses on the system clock; latency set by the bench.
`timescale 1ns/10ps
module converter_model
(
    input  wire logic        clk_sys_in,
    input  wire logic        arst_n_in,
    input  wire logic        start_in,
    input  wire logic        channel_in,
    input  wire logic        differential_in,
    input  wire logic        mute_in,
    input  wire logic [7:0]  latency_in,
    input  wire logic [15:0] shunt_val_in,
    input  wire logic [15:0] bus_val_in,
    output logic      [15:0] result_out,
    output logic             done_out
);
    logic [7:0]  wait_q;
    logic        busy_q;
    logic        chan_q;
    logic        diff_q;
    logic [15:0] pick;
    assign pick = chan_q ? bus_val_in : shunt_val_in;
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            busy_q     <= 1'b0;
            done_out   <= 1'b0;
            result_out <= 16'h0000;
        end
        else
        begin
            done_out   <= 1'b0;
            // Data wander outside the result cycle, so late samples show.
            result_out <= ~result_out;
            if (start_in)
            begin
                busy_q <= 1'b1;
                wait_q <= latency_in;
                chan_q <= channel_in;
                diff_q <= differential_in;
            end
            else if (busy_q && !mute_in && wait_q > 8'h01)
                wait_q <= wait_q - 8'h01;
            else if (busy_q && !mute_in)
            begin
                busy_q     <= 1'b0;
                done_out   <= 1'b1;
                // A wrong pairing measures the wrong node.
                result_out <= (diff_q == chan_q) ? ~pick : pick;
            end
        end
    end
endmodule : converter_model

// ### dv/tb_top.sv
// Bench for the current and power averager with a converter model.
// Assumes the monitor and converter model are compiled before it.
`timescale 1ns/10ps
`include "averager_map.svh"
`define CHK(got, exp) \
    begin \
        tests_run++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("ERROR %0t: got %h want %h", $time, got, exp); \
        end \
    end
module tb_top;
    logic        clk_sys_in = 1'b0;
    logic        arst_n_in  = 1'b0;
    logic [3:0]  addr_in    = 4'h0;
    logic [15:0] wdata_in   = 16'h0000;
    logic        wr_in      = 1'b0;
    logic        rd_in      = 1'b0;
    logic        mute       = 1'b0;
    logic [7:0]  lat        = 8'h03;
    logic [15:0] shunt_v    = 16'h0100;
    logic [15:0] bus_v      = 16'h1000;
    logic        pend_q     = 1'b0;
    logic [15:0] rdata_out, conv_result_in, c_v, cur_e, pow_e, prev;
    logic        conv_start_out, conv_channel_out, conv_differential_out;
    logic        conv_done_in, irq_out;
    logic [31:0] note;
    logic [31:0] notes[$];
    int          failures   = 0;
    int          tests_run  = 0;
    int          starts     = 0;
    int          cycles     = 0;
    int          base, i;
    int          seed       = 32'h8a3e;
    always #20 clk_sys_in = ~clk_sys_in;
    current_power_averager #(.CONV_CYCLES_P(10)) i_current_power_averager (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .conv_start_out(conv_start_out),
        .conv_channel_out(conv_channel_out),
        .conv_differential_out(conv_differential_out),
        .conv_result_in(conv_result_in), .conv_done_in(conv_done_in),
        .irq_out(irq_out));
    converter_model i_converter_model (
        .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .start_in(conv_start_out), .channel_in(conv_channel_out),
        .differential_in(conv_differential_out), .mute_in(mute),
        .latency_in(lat), .shunt_val_in(shunt_v), .bus_val_in(bus_v),
        .result_out(conv_result_in), .done_out(conv_done_in));
    function automatic logic [15:0] cur_of(logic [15:0] s, logic [15:0] c);
        int p;
        p = $signed(s) * $signed({16'h0000, c});
        return 16'(p >>> 11);
    endfunction : cur_of
    function automatic logic [15:0] pow_of(logic [15:0] cur, logic [15:0] b);
        int m;
        m = $signed(cur);
        if (m < 0)
            m = -m;
        return 16'((m * $signed({16'h0000, b})) >>> 13);
    endfunction : pow_of
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_in  <= a;
        wdata_in <= d;
        wr_in    <= w;
        rd_in    <= ~w;
        @(posedge clk_sys_in);
        wr_in    <= 1'b0;
        rd_in    <= 1'b0;
    endtask : bus
    task automatic rd(input logic [3:0] a, input logic [15:0] e,
                      input logic [15:0] m);
        notes.push_back({m, e & m});
        bus(1'b0, a, 16'h0000);
    endtask : rd
    task automatic wait_irq();
        for (i = 0; i < 800 && irq_out !== 1'b1; i++)
            @(negedge clk_sys_in);
        `CHK(irq_out, 1'b1)
    endtask : wait_irq
    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    // Read answers are judged one cycle after the strobe, oldest note first.
    always @(posedge clk_sys_in)
    begin
        cycles++;
        if (conv_start_out)
            starts++;
        if (pend_q)
        begin
            note = notes.pop_front();
            `CHK(rdata_out & note[31:16], note[15:0])
        end
        pend_q <= rd_in;
        if (cycles == 6000)
        begin
            failures++;
            summarize();
        end
    end
    initial
    begin
        prev = 16'h0000;
        repeat (20) @(posedge clk_sys_in);
        arst_n_in <= 1'b1;
        rd(`REG_CONFIG_OFS, `CFG_RESET_VAL, 16'hffff);
        rd(`REG_CALIB_OFS, `CALIB_RESET_VAL, 16'hffff);
        rd(`REG_MASK_OFS, `MASK_RESET_VAL, 16'hffff);
        rd(4'hc, 16'h0000, 16'hffff);
        $display("test reset values done");
        bus(1'b1, `REG_MASK_OFS, 16'h0001);
        wait_irq();
        rd(`REG_STATUS_OFS, 16'h0001, 16'h0003);
        @(negedge clk_sys_in);
        `CHK(irq_out, 1'b0)
        rd(`REG_POWER_OFS, 16'h0000, 16'hffff);
        $display("test continuous zero calibration done");
        bus(1'b1, `REG_MASK_OFS, 16'h0000);
        bus(1'b1, `REG_CONFIG_OFS, 16'h0000);
        repeat (200) @(negedge clk_sys_in);
        `CHK(irq_out, 1'b0)
        rd(`REG_STATUS_OFS, 16'h0001, 16'h0003);
        $display("test masked done flag done");
        for (int k = 0; k < 4; k++)
        begin
            shunt_v <= 16'($random(seed) % 1024);
            bus_v   <= 16'($random(seed));
            lat     <= 8'($random(seed)) & 8'h0f | 8'h01;
            c_v = 16'($random(seed)) & 16'h0fff;
            bus(1'b1, `REG_CALIB_OFS, c_v);
            cur_e = cur_of(shunt_v, c_v);
            pow_e = (c_v == 16'h0000) ? 16'h0000 : pow_of(cur_e, bus_v);
            bus(1'b1, `REG_MASK_OFS, 16'h0001);
            base = starts;
            bus(1'b1, `REG_CONFIG_OFS, (k % 2) ? 16'h0011 : 16'h0001);
            if (k % 2)
            begin
                for (i = 0; i < 400 && starts - base < 5; i++)
                    @(negedge clk_sys_in);
                rd(`REG_CURRENT_OFS, prev, 16'hffff);
            end
            wait_irq();
            rd(`REG_STATUS_OFS, 16'h0001, 16'h0003);
            rd(`REG_CURRENT_OFS, cur_e, 16'hffff);
            rd(`REG_POWER_OFS, pow_e, 16'hffff);
            rd(`REG_SHUNT_OFS, shunt_v, 16'hffff);
            rd(`REG_BUS_OFS, bus_v, 16'hffff);
            bus(1'b1, `REG_CURRENT_OFS, ~cur_e);
            repeat (100) @(negedge clk_sys_in);
            rd(`REG_CURRENT_OFS, cur_e, 16'hffff);
            `CHK(starts - base, (k % 2) ? 8 : 2)
            prev = cur_e;
            $display("test single set %0d done", k);
        end
        mute <= 1'b1;
        bus(1'b1, `REG_CONFIG_OFS, 16'h0001);
        repeat (120) @(negedge clk_sys_in);
        rd(`REG_STATUS_OFS, 16'h0002, 16'h0003);
        rd(`REG_CURRENT_OFS, prev, 16'hffff);
        repeat (3) @(negedge clk_sys_in);
        $display("test converter silence done");
        summarize();
    end
endmodule : tb_top
bind current_power_averager averager_monitor i_averager_monitor (
    .clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
    .rd_in(rd_in), .wr_in(wr_in), .rdata_out(rdata_out),
    .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out),
    .conv_differential_out(conv_differential_out),
    .conv_done_in(conv_done_in), .irq_out(irq_out));
